/* rtl/olt_pkg.sv */
// Shared constants and types for output enable and oscillator trim control
package olt_pkg;

   // ==========================================================
   // Register map (7-bit serial address)
   localparam logic [6:0] OLT_ADDR_FUNC = 7'h00;
   localparam logic [6:0] OLT_ADDR_TRIM = 7'h1C;
   localparam logic [6:0] OLT_ADDR_CNT_LO = 7'h41;
   localparam logic [6:0] OLT_ADDR_CNT_HI = 7'h42;

   // ==========================================================
   // Function control field positions
   localparam int OLT_FC_LOCK = 0;
   localparam int OLT_FC_OUT1 = 1;
   localparam int OLT_FC_OUT2 = 2;
   localparam int OLT_FC_CNT_EN = 3;
   localparam int OLT_FC_BITS = 4;
   localparam int OLT_TRIM_BITS = 6;

   // ==========================================================
   // Values after reset, and the count limit
   localparam logic [3:0] OLT_FC_RESET = 4'h0;
   localparam logic [5:0] OLT_TRIM_NOMINAL = 6'h09;
   localparam logic [15:0] OLT_CNT_RESET = 16'h0000;
   localparam logic [15:0] OLT_CNT_MAX = 16'hFFFF;

   // ==========================================================
   // Serial frame: write flag, 7 address bits, 8 data bits
   localparam logic [4:0] OLT_FRAME_BITS = 5'h10;
   localparam logic [4:0] OLT_ADDR_DONE = 5'h07;
   localparam logic [4:0] OLT_DATA_START = 5'h08;

   // ==========================================================
   // Timing
   localparam int OLT_CLK_HZ = 10_000_000;
   localparam int OLT_GATE_STARTUP_US = 100;
   localparam int OLT_GATE_STARTUP_CYC =
      (OLT_GATE_STARTUP_US * (OLT_CLK_HZ / 1_000_000) < 1) ? 1 :
      OLT_GATE_STARTUP_US * (OLT_CLK_HZ / 1_000_000);
   localparam int OLT_OSC_DIV = 1;

   // ==========================================================
   // Gate driver sequencing states
   typedef enum logic [1:0] {
      OLT_GATE_OFF = 2'b00,
      OLT_GATE_STARTUP = 2'b01,
      OLT_GATE_RUN = 2'b10
   } olt_gate_state_t;

   // Listed trim codes: odd codes, except 100101 up to 101111
   function automatic logic olt_trim_legal(input logic [5:0] code);
      olt_trim_legal = code[0] & ~((code[5:4] == 2'b10) &
                                   (code[3:1] > 3'h1));
   endfunction

endpackage

/* rtl/olt_serial_slave.sv */
// Serial register slave working on synchronised pin levels and edges
`timescale 1ns/1ns
module olt_serial_slave
   import olt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_frame_start,
   input wire logic i_frame_end,
   input wire logic i_select_low,
   input wire logic i_sck_rise,
   input wire logic i_sck_fall,
   input wire logic i_mosi,
   input wire logic [7:0] i_rdata,
   output logic [6:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata,
   output logic o_miso
);

   logic [15:0] shift_q;
   logic [4:0] bits_q;
   logic write_q;
   logic [6:0] tx_q;

   // ==========================================================
   // Receive shifter
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         shift_q <= 16'h0000;
         bits_q <= 5'h00;
         write_q <= 1'b0;
         o_addr <= 7'h00;
      end else if (i_frame_start) begin
         bits_q <= 5'h00;
      end else if (i_sck_rise && i_select_low) begin
         shift_q <= {shift_q[14:0], i_mosi};
         if (bits_q == OLT_ADDR_DONE) begin
            write_q <= shift_q[6];
            o_addr <= {shift_q[5:0], i_mosi};
         end
         // The bit count stops at one frame; extra clocks still shift the data
         if (bits_q != OLT_FRAME_BITS) begin
            bits_q <= bits_q + 5'h01;
         end
      end
   end

   // ==========================================================
   // Read data, MSB first, changed on falling clock
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_miso <= 1'b0;
         tx_q <= 7'h00;
      end else if (i_frame_start) begin
         o_miso <= 1'b0;
      end else if (i_sck_fall && i_select_low) begin
         if (bits_q == OLT_DATA_START) begin
            o_miso <= i_rdata[7];
            tx_q <= i_rdata[6:0];
         end else if (bits_q > OLT_DATA_START) begin
            o_miso <= tx_q[6];
            tx_q <= {tx_q[5:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // Writes commit only for a complete frame, at its end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_wr <= 1'b0;
         o_wdata <= 8'h00;
      end else begin
         o_wr <= i_frame_end && (bits_q == OLT_FRAME_BITS) && write_q;
         if (i_frame_end) begin
            o_wdata <= shift_q[7:0];
         end
      end
   end

endmodule

/* rtl/olt_low_counter.sv */
// Chip select low-time counter with publish and freeze
`timescale 1ns/1ns
module olt_low_counter
   import olt_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_tick,
   input wire logic i_select_low,
   input wire logic i_frame_start,
   input wire logic i_frame_end,
   input wire logic i_enable,
   output logic [15:0] o_count
);

   logic [15:0] run_q;
   logic armed_q;

   // ==========================================================
   // Arming is taken at frame start, so the frame that clears
   // the enable still publishes its own length
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         armed_q <= 1'b0;
      end else if (i_frame_start) begin
         armed_q <= i_enable;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         run_q <= OLT_CNT_RESET;
      end else if (i_frame_start) begin
         run_q <= OLT_CNT_RESET;
      end else if (i_select_low && i_tick && (run_q != OLT_CNT_MAX)) begin
         run_q <= run_q + 16'h0001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_count <= OLT_CNT_RESET;
      end else if (i_frame_end && armed_q) begin
         o_count <= run_q;
      end
   end

endmodule

/* rtl/olt_control.sv */
// Output enables, gate driver start-up and oscillator trim control
`timescale 1ns/1ns
module olt_control
   import olt_pkg::*;
#(
   parameter int STARTUP_CYC = OLT_GATE_STARTUP_CYC,
   parameter int OSC_DIV = OLT_OSC_DIV
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_chip_select_pin_n,
   input wire logic i_spi_sck,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   input wire logic i_operation_mode,
   input wire logic i_gate_supply_good,
   output logic o_first_output_enable,
   output logic o_second_output_enable,
   output logic o_gate_regulator_on,
   output logic o_gate_drive_enable,
   output logic o_configuration_lock,
   output logic [5:0] o_osc_trim
);

   localparam int NSYNC = 4;
   localparam int SY_CS = 0;
   localparam int SY_SCK = 1;
   localparam int SY_MOSI = 2;
   localparam int SY_GOOD = 3;
   localparam int DIVW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
   localparam int STW = $clog2(STARTUP_CYC + 1);
   // Reset stages to the idle levels so no false edge follows reset
   localparam logic [NSYNC-1:0] PIN_IDLE = 4'h1;

   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] s3_q;
   logic [NSYNC-1:0] lvl_q;
   logic [NSYNC-1:0] lvl_d;

   logic select_low;
   logic frame_start;
   logic frame_end;
   logic sck_rise;
   logic sck_fall;
   logic gate_good;

   logic [OLT_FC_BITS-1:0] func_q;
   logic [5:0] trim_q;
   logic [15:0] count;
   logic [6:0] addr;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   logic [DIVW-1:0] div_q;
   logic tick;

   olt_gate_state_t gate_q;
   logic [STW-1:0] start_q;
   logic out1_on;
   logic out2_on;
   logic any_on;

   // ==========================================================
   // Pin synchronisers: three stages, change taken once
   // the second and third stages agree
   assign pins = {i_gate_supply_good, i_spi_mosi, i_spi_sck,
                  i_chip_select_pin_n};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
               s1_q[g] <= PIN_IDLE[g];
               s2_q[g] <= PIN_IDLE[g];
               s3_q[g] <= PIN_IDLE[g];
            end else begin
               s1_q[g] <= pins[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
            end
         end
         assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
   endgenerate

   // Idle pin levels: select high, clock low, supply good low
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         lvl_q <= PIN_IDLE;
      end else begin
         lvl_q <= lvl_d;
      end
   end

   assign select_low = ~lvl_q[SY_CS];
   assign frame_start = lvl_q[SY_CS] & ~lvl_d[SY_CS];
   assign frame_end = ~lvl_q[SY_CS] & lvl_d[SY_CS];
   assign sck_rise = ~lvl_q[SY_SCK] & lvl_d[SY_SCK];
   assign sck_fall = lvl_q[SY_SCK] & ~lvl_d[SY_SCK];
   assign gate_good = lvl_q[SY_GOOD];

   // ==========================================================
   // Serial slave
   olt_serial_slave u_slave (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_frame_start(frame_start),
      .i_frame_end(frame_end),
      .i_select_low(select_low),
      .i_sck_rise(sck_rise),
      .i_sck_fall(sck_fall),
      .i_mosi(lvl_d[SY_MOSI]),
      .i_rdata(rdata),
      .o_addr(addr),
      .o_wr(wr),
      .o_wdata(wdata),
      .o_miso(o_spi_miso)
   );

   // ==========================================================
   // Oscillator period tick; the system clock stands for the
   // trimmed oscillator, so one tick is OSC_DIV trimmed periods
   generate
      if (OSC_DIV > 1) begin : g_div
         always_ff @(posedge i_clk) begin
            if (!i_resetn) begin
               div_q <= '0;
            end else if (div_q == DIVW'(OSC_DIV - 1)) begin
               div_q <= '0;
            end else begin
               div_q <= div_q + DIVW'(1);
            end
         end
         assign tick = (div_q == DIVW'(OSC_DIV - 1));
      end else begin : g_nodiv
         always_ff @(posedge i_clk) begin
            div_q <= '0;
         end
         assign tick = 1'b1;
      end
   endgenerate

   // ==========================================================
   // Low-time counter
   olt_low_counter u_count (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_tick(tick),
      .i_select_low(select_low),
      .i_frame_start(frame_start),
      .i_frame_end(frame_end),
      .i_enable(func_q[OLT_FC_CNT_EN]),
      .o_count(count)
   );

   // ==========================================================
   // Register writes
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         func_q <= OLT_FC_RESET;
      end else if (wr && (addr == OLT_ADDR_FUNC)) begin
         // Reserved upper bits are not stored and read as zero
         func_q[OLT_FC_CNT_EN] <= wdata[OLT_FC_CNT_EN];
         func_q[OLT_FC_OUT2] <= wdata[OLT_FC_OUT2];
         func_q[OLT_FC_OUT1] <= wdata[OLT_FC_OUT1];
         // Lock only sets; it is released by reset alone
         func_q[OLT_FC_LOCK] <= func_q[OLT_FC_LOCK] |
                                wdata[OLT_FC_LOCK];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         trim_q <= OLT_TRIM_NOMINAL;
      end else if (wr && (addr == OLT_ADDR_TRIM) &&
                   !func_q[OLT_FC_LOCK] &&
                   olt_trim_legal(wdata[5:0])) begin
         // Unlisted codes are dropped so the oscillator never
         // leaves its characterised range
         trim_q <= wdata[5:0];
      end
   end

   // ==========================================================
   // Register reads; unmapped addresses read zero
   always_comb begin
      rdata = 8'h00;
      if (addr == OLT_ADDR_FUNC) begin
         rdata = {4'h0, func_q};
      end else if (addr == OLT_ADDR_TRIM) begin
         rdata = {2'b00, trim_q};
      end else if (addr == OLT_ADDR_CNT_LO) begin
         rdata = count[7:0];
      end else if (addr == OLT_ADDR_CNT_HI) begin
         rdata = count[15:8];
      end
   end

   // ==========================================================
   // Output enables and gate supply
   assign out1_on = func_q[OLT_FC_OUT1] & i_operation_mode;
   assign out2_on = func_q[OLT_FC_OUT2] & i_operation_mode;
   assign any_on = out1_on | out2_on;

   // ==========================================================
   // Gate driver start-up sequencing
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         gate_q <= OLT_GATE_OFF;
         start_q <= '0;
      end else begin
         case (gate_q)
            OLT_GATE_OFF: begin
               start_q <= '0;
               if (any_on) begin
                  gate_q <= OLT_GATE_STARTUP;
               end
            end
            OLT_GATE_STARTUP: begin
               if (!any_on) begin
                  gate_q <= OLT_GATE_OFF;
               end else if (start_q == STW'(STARTUP_CYC - 1)) begin
                  gate_q <= OLT_GATE_RUN;
               end else begin
                  start_q <= start_q + STW'(1);
               end
            end
            OLT_GATE_RUN: begin
               if (!any_on) begin
                  gate_q <= OLT_GATE_OFF;
               end
            end
            default: begin
               gate_q <= OLT_GATE_OFF;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_first_output_enable <= 1'b0;
         o_second_output_enable <= 1'b0;
      end else begin
         o_first_output_enable <= out1_on;
         o_second_output_enable <= out2_on;
      end
   end

   // Regulator changes in the same cycle as the output enables
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_gate_regulator_on <= 1'b0;
      end else begin
         o_gate_regulator_on <= any_on;
      end
   end

   // Supply good is rechecked every cycle, so a drop stops the
   // drivers within five clocks without repeating the start-up wait
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_gate_drive_enable <= 1'b0;
      end else begin
         o_gate_drive_enable <= (gate_q == OLT_GATE_RUN) & any_on &
                                gate_good;
      end
   end

   assign o_configuration_lock = func_q[OLT_FC_LOCK];
   assign o_osc_trim = trim_q;

endmodule

/* test/olt_control_sva.sv */
// Port checker for the output enable and trim control block
`timescale 1ns/1ns
module olt_control_sva #(
   parameter int STARTUP_CYC = 8
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_chip_select_pin_n,
   input wire logic i_operation_mode,
   input wire logic i_gate_supply_good,
   input wire logic o_first_output_enable,
   input wire logic o_second_output_enable,
   input wire logic o_gate_regulator_on,
   input wire logic o_gate_drive_enable,
   input wire logic o_configuration_lock,
   input wire logic [5:0] o_osc_trim
);
   // ==========
   // Cycles the regulator has been on without a break
   int on_cnt_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn || !o_gate_regulator_on) begin
         on_cnt_q <= 0;
      end else if (on_cnt_q < 1000) begin
         on_cnt_q <= on_cnt_q + 1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // ==========
   // Assertions
   chk_mode_off: assert property (
      !i_operation_mode |=>
      !o_first_output_enable && !o_second_output_enable)
      else $error("output on outside operation mode");
   chk_out1_cause: assert property (
      $rose(o_first_output_enable) |->
      $past(i_operation_mode) && i_chip_select_pin_n)
      else $error("first output rose without cause");
   chk_reg_on: assert property (
      $rose(o_first_output_enable || o_second_output_enable) |->
      ##[0:1] o_gate_regulator_on)
      else $error("regulator late");
   chk_reg_off: assert property (
      (!o_first_output_enable && !o_second_output_enable) [*2] |->
      !o_gate_regulator_on)
      else $error("regulator on with outputs off");
   chk_drive_wait: assert property (
      o_gate_drive_enable |-> on_cnt_q >= STARTUP_CYC)
      else $error("drivers switch before start-up time");
   chk_drive_good: assert property (
      !i_gate_supply_good [*6] |-> !o_gate_drive_enable)
      else $error("drivers switch without supply good");
   chk_lock_sticky: assert property (
      $past(i_resetn) && $past(o_configuration_lock) |->
      o_configuration_lock)
      else $error("lock cleared without reset");
   chk_trim_legal: assert property (
      o_osc_trim[0] && !(o_osc_trim[5:4] == 2'b10 && o_osc_trim[3:1] > 3'h1))
      else $error("trim outside listed codes");
   chk_trim_frame: assert property (
      $changed(o_osc_trim) && $past(i_resetn) |->
      i_chip_select_pin_n && $past(i_chip_select_pin_n, 3))
      else $error("trim changed inside a frame");
   chk_reset_vals: assert property (
      $rose(i_resetn) |-> o_osc_trim == 6'h09 && !o_configuration_lock &&
      !o_first_output_enable && !o_second_output_enable)
      else $error("bad value after reset");
endmodule

bind olt_control olt_control_sva #(.STARTUP_CYC(STARTUP_CYC)) u_sva (
   .i_clk(i_clk),
   .i_resetn(i_resetn),
   .i_chip_select_pin_n(i_chip_select_pin_n),
   .i_operation_mode(i_operation_mode),
   .i_gate_supply_good(i_gate_supply_good),
   .o_first_output_enable(o_first_output_enable),
   .o_second_output_enable(o_second_output_enable),
   .o_gate_regulator_on(o_gate_regulator_on),
   .o_gate_drive_enable(o_gate_drive_enable),
   .o_configuration_lock(o_configuration_lock),
   .o_osc_trim(o_osc_trim)
);

/* test/olt_spi_master.sv */
// Serial master model standing in for the calibrating controller
`timescale 1ns/1ns
module olt_spi_master (
   output logic o_cs_n,
   output logic o_sck,
   output logic o_mosi,
   input wire logic i_miso
);
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b1;
   end
   // ==========
   // One frame, select low for 12800 ns plus pad_ns
   task automatic xfer(input logic wr, input logic [6:0] addr,
      input logic [7:0] wdata, input int pad_ns, output logic [7:0] rdata);
      logic [15:0] word;
      word = {wr, addr, wdata};
      rdata = 8'h00;
      o_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         o_mosi = word[i];
         #400 o_sck = 1'b1;
         rdata[i[2:0]] = (i < 8) ? i_miso : rdata[i[2:0]];
         #400 o_sck = 1'b0;
      end
      // Released line has no pull, so it must not keep the last bit
      o_mosi = ~o_mosi;
      #(pad_ns) o_cs_n = 1'b1;
      #1200;
   endtask
endmodule

/* test/olt_control_tb.sv */
// Self-checking bench for the output enable and trim control block
`timescale 1ns/1ns
module olt_control_tb;
   import olt_pkg::*;
   localparam int STARTUP = 8;
   // One bit per listed trim code, written out from the code table
   localparam logic [63:0] TRIM_LIST = 64'hAAAA_000A_AAAA_AAAA;
   logic i_clk, i_resetn, cs_n, sck, mosi, miso, op_mode, good;
   logic out1, out2, reg_on, drive, lock;
   logic [5:0] trim;
   logic [7:0] rd;
   logic [7:0] lo;
   int errors, samples_checked;

   always #50 i_clk = ~i_clk;

   olt_spi_master u_master (.o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi),
      .i_miso(miso));
   olt_control #(.STARTUP_CYC(STARTUP)) dut (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_chip_select_pin_n(cs_n), .i_spi_sck(sck),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .i_operation_mode(op_mode),
      .i_gate_supply_good(good), .o_first_output_enable(out1),
      .o_second_output_enable(out2), .o_gate_regulator_on(reg_on),
      .o_gate_drive_enable(drive), .o_configuration_lock(lock),
      .o_osc_trim(trim));

   // ==========
   // Shared tasks
   task automatic check(input logic [15:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Synchroniser skew may add or drop one count
   task automatic check_near(input logic [15:0] got, exp, input string s);
      samples_checked++;
      if (!(got === exp || got === exp + 1 || got === exp - 1)) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, s, got, exp);
      end
   endtask
   // Pin edges sit 37 ns after a clock edge, so read data launched
   // by the synchronised clock fall settles before the link samples it
   task automatic align();
      @(posedge i_clk);
      #37;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input int p);
      align();
      u_master.xfer(1'b1, a, d, p, rd);
   endtask
   task automatic rdreg(input logic [6:0] a);
      align();
      u_master.xfer(1'b0, a, 8'h00, 200, rd);
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      check(16'(trim), 16'h0009, "trim port");
      check(16'({out1, out2, reg_on, drive, lock}), 16'h0000, "outs");
      rdreg(OLT_ADDR_FUNC);
      check(16'(rd), 16'h0000, "func");
      rdreg(OLT_ADDR_TRIM);
      check(16'(rd), 16'h0009, "trim reg");
      $display("reset test done");
   endtask
   task automatic t_outputs();
      int n;
      @(posedge i_clk) good <= 1'b1;
      wr(OLT_ADDR_FUNC, 8'h06, 200);
      check(16'({out1, out2, reg_on}), 16'h0000, "no op mode");
      @(posedge i_clk) op_mode <= 1'b1;
      for (n = 0; n < 40 && drive !== 1'b1; n++) @(posedge i_clk);
      if (drive !== 1'b1) begin
         errors++;
         $display("BAD %0t drive timeout", $time);
         conclude();
      end
      check(16'(n > STARTUP), 16'h0001, "start-up wait");
      check(16'({out1, out2, reg_on}), 16'h0007, "both on");
      @(posedge i_clk) good <= 1'b0;
      repeat (6) @(posedge i_clk);
      check(16'(drive), 16'h0000, "drive without good");
      good <= 1'b1;
      wr(OLT_ADDR_FUNC, 8'h02, 200);
      check(16'({out1, out2, reg_on}), 16'h0005, "first only");
      wr(OLT_ADDR_FUNC, 8'h04, 200);
      check(16'({out1, out2, reg_on}), 16'h0003, "second only");
      @(posedge i_clk) op_mode <= 1'b0;
      repeat (3) @(posedge i_clk);
      check(16'({out1, out2, reg_on}), 16'h0000, "mode off");
      $display("outputs test done");
   endtask
   task automatic t_count(input int pad);
      logic [15:0] exp;
      exp = ((12800 + pad) / 100 > 65535) ? 16'hFFFF :
            16'((12800 + pad) / 100);
      wr(OLT_ADDR_FUNC, 8'h08, 200);
      wr(OLT_ADDR_FUNC, 8'h00, pad);
      for (int k = 0; k < 2; k++) begin
         rdreg(OLT_ADDR_CNT_LO);
         lo = rd;
         rdreg(OLT_ADDR_CNT_HI);
         check_near({rd, lo}, exp, "low count");
         // A frame of a different length with counting off must not republish
         wr(OLT_ADDR_TRIM, 8'h09, 4000);
      end
      $display("count test done");
   endtask
   task automatic t_trim();
      logic [5:0] want;
      want = 6'h09;
      for (int c = 0; c < 64; c++) begin
         wr(OLT_ADDR_TRIM, 8'(c), 200);
         if (TRIM_LIST[c]) want = 6'(c);
         check(16'(trim), 16'(want), "trim code");
      end
      rdreg(OLT_ADDR_TRIM);
      check(16'(rd), 16'(want), "trim readback");
      wr(OLT_ADDR_FUNC, 8'h01, 200);
      check(16'(lock), 16'h0001, "lock set");
      wr(OLT_ADDR_TRIM, 8'h09, 200);
      check(16'(trim), 16'(want), "trim locked");
      wr(OLT_ADDR_FUNC, 8'h00, 200);
      rdreg(OLT_ADDR_FUNC);
      check(16'(rd), 16'h0001, "lock stays");
      $display("trim test done");
   endtask

   initial begin
      #9_800_000;
      errors++;
      $display("BAD %0t run did not finish", $time);
      conclude();
   end
   initial begin
      i_clk = 1'b0;
      i_resetn = 1'b0;
      op_mode = 1'b0;
      good = 1'b0;
      errors = 0;
      samples_checked = 0;
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (6) @(posedge i_clk);
      // Link runs out of phase with the system clock
      #37;
      t_reset();
      t_outputs();
      t_count(200);
      t_count(3000);
      t_count(6_560_000);
      t_trim();
      conclude();
   end
endmodule
